// ==== hw/three_wire_latch_loader.sv ====
// Serial programming port: pin capture, latch bank, power and monitor control
//
// Functional notes
// - Serial data enters a 24-bit shift register, one bit per serial clock rise.
// - Words arrive top bit first; the two lowest bits select the latch.
// - A load strobe rise copies the shift register into exactly one latch.
// - Chip enable low powers down and floats the charge pump output.
// - Chip enable high powers up only as far as power-down bits allow.
// - Monitor output shows lock detect, scaled feedback or scaled reference.
// - Select 00 control, 01 reference, 10 feedback, 11 test latch.
`timescale 1ns/1ns
module three_wire_latch_loader (
   input  wire logic                          clk_i,
   input  wire logic                          nrst_i,
   input  wire logic                          clk_en_i,
   input  wire logic                          serial_clock_i,
   input  wire logic                          serial_data_i,
   input  wire logic                          load_strobe_i,
   input  wire logic                          chip_enable_i,
   input  wire logic                          lock_detect_i,
   input  wire logic                          rf_scaled_i,
   input  wire logic                          ref_scaled_i,
   input  wire logic                          pump_level_i,
   output logic                               monitor_output_o,
   output logic                               charge_pump_output_o,
   output logic                               charge_pump_output_oe_n_o,
   output logic                               core_power_on_o,
   output logic [loader_pkg::WORD_W-1:0]      control_latch_o,
   output logic [loader_pkg::WORD_W-1:0]      ref_counter_latch_o,
   output logic [loader_pkg::WORD_W-1:0]      feedback_counter_latch_o,
   output logic [loader_pkg::WORD_W-1:0]      test_latch_o
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // All four pins are asynchronous to clk_i. Clock and data pass the same
   // two stages, so the data bit seen with a clock rise is the one the host
   // set up before that rise.
   logic [loader_pkg::SYNC_N-1:0] sck_sync_reg;
   logic [loader_pkg::SYNC_N-1:0] sdi_sync_reg;
   logic [loader_pkg::SYNC_N-1:0] le_sync_reg;
   logic [loader_pkg::SYNC_N-1:0] ce_sync_reg;
   logic                          sck_prev_reg;
   logic                          le_prev_reg;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sck_sync_reg <= 2'h0;
         sdi_sync_reg <= 2'h0;
         le_sync_reg  <= 2'h0;
         ce_sync_reg  <= 2'h0;
      end else if (clk_en_i) begin
         sck_sync_reg <= {sck_sync_reg[0], serial_clock_i};
         sdi_sync_reg <= {sdi_sync_reg[0], serial_data_i};
         le_sync_reg  <= {le_sync_reg[0], load_strobe_i};
         ce_sync_reg  <= {ce_sync_reg[0], chip_enable_i};
      end
   end

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   // Previous values start high, but the synchronisers reset low, so a pin
   // already high at reset release still gives one rising edge.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sck_prev_reg <= 1'h1;
         le_prev_reg  <= 1'h1;
      end else if (clk_en_i) begin
         sck_prev_reg <= sck_sync_reg[1];
         le_prev_reg  <= le_sync_reg[1];
      end
   end

   serial_evt_if evt ();

   assign evt.shift_strobe = sck_sync_reg[1] & ~sck_prev_reg;
   assign evt.data_bit     = sdi_sync_reg[1];
   assign evt.load_strobe  = le_sync_reg[1] & ~le_prev_reg;

   latch_bank u_latch_bank (
      .clk_i    (clk_i),
      .nrst_i   (nrst_i),
      .clk_en_i (clk_en_i),
      .evt      (evt.bank)
   );

   assign control_latch_o          = evt.latch[loader_pkg::SEL_CONTROL];
   assign ref_counter_latch_o      = evt.latch[loader_pkg::SEL_REF];
   assign feedback_counter_latch_o = evt.latch[loader_pkg::SEL_FEEDBACK];
   assign test_latch_o             = evt.latch[loader_pkg::SEL_TEST];

   // ----------------------------------------------------------------
   // Power control
   // ----------------------------------------------------------------
   logic power_next;
   logic power_reg;

   // Either power-down bit keeps the core off even with chip enable high
   assign power_next = ce_sync_reg[1]
                       & ~control_latch_o[loader_pkg::PD1_BIT]
                       & ~control_latch_o[loader_pkg::PD2_BIT];

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         power_reg <= 1'h0;
      end else if (clk_en_i) begin
         power_reg <= power_next;
      end
   end

   assign core_power_on_o = power_reg;

   // ----------------------------------------------------------------
   // Charge pump drive
   // ----------------------------------------------------------------
   logic pump_reg;
   logic pump_oe_n_reg;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pump_reg      <= 1'h0;
         pump_oe_n_reg <= 1'h1;
      end else if (clk_en_i) begin
         // Floated while powered down; level zeroed so nothing stale leaks
         pump_oe_n_reg <= ~power_next;
         pump_reg      <= power_next & pump_level_i;
      end
   end

   assign charge_pump_output_o      = pump_reg;
   assign charge_pump_output_oe_n_o = pump_oe_n_reg;

   // ----------------------------------------------------------------
   // Monitor multiplexer
   // ----------------------------------------------------------------
   // Selection stays live in power-down so lock state can still be watched.
   loader_pkg::mon_sel_e mon_sel;
   logic                 mon_next;
   logic                 mon_reg;

   assign mon_sel = loader_pkg::mon_sel_e'(control_latch_o[loader_pkg::MON_LSB +: loader_pkg::MON_W]);

   always_comb begin
      case (mon_sel)
         loader_pkg::MON_LOCK: begin
            mon_next = lock_detect_i;
         end
         loader_pkg::MON_RF: begin
            mon_next = rf_scaled_i;
         end
         loader_pkg::MON_REF: begin
            mon_next = ref_scaled_i;
         end
         default: begin
            mon_next = 1'h0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mon_reg <= 1'h0;
      end else if (clk_en_i) begin
         mon_reg <= mon_next;
      end
   end

   assign monitor_output_o = mon_reg;

endmodule : three_wire_latch_loader

// ==== hw/loader_pkg.sv ====
// Shared constants and types for the three-wire latch loader
package loader_pkg;

   // ----------------------------------------------------------------
   // Word and latch geometry
   // ----------------------------------------------------------------
   localparam int WORD_W  = 24;
   localparam int SEL_W   = 2;
   localparam int SEL_LSB = 0;
   localparam int LATCH_N = 4;
   localparam int SYNC_N  = 2;

   typedef logic [WORD_W-1:0] word_t;

   typedef enum logic [SEL_W-1:0] {
      SEL_CONTROL  = 2'h0,
      SEL_REF      = 2'h1,
      SEL_FEEDBACK = 2'h2,
      SEL_TEST     = 2'h3
   } latch_sel_e;

   localparam word_t LATCH_RESET = 24'h000000;

   // ----------------------------------------------------------------
   // Control latch fields
   // ----------------------------------------------------------------
   localparam int PD1_BIT = 20;
   localparam int PD2_BIT = 21;
   localparam int MON_LSB = 5;
   localparam int MON_W   = 3;

   typedef enum logic [MON_W-1:0] {
      MON_LOW  = 3'h0,
      MON_LOCK = 3'h1,
      MON_RF   = 3'h2,
      MON_REF  = 3'h3
   } mon_sel_e;

endpackage : loader_pkg

// ==== hw/serial_evt_if.sv ====
// Interface carrying serial events and latch contents between the two modules
`timescale 1ns/1ns
interface serial_evt_if;
   logic                                          shift_strobe;
   logic                                          data_bit;
   logic                                          load_strobe;
   logic [loader_pkg::LATCH_N-1:0][loader_pkg::WORD_W-1:0] latch;

   modport front (
      output shift_strobe,
      output data_bit,
      output load_strobe,
      input  latch
   );

   modport bank (
      input  shift_strobe,
      input  data_bit,
      input  load_strobe,
      output latch
   );
endinterface : serial_evt_if

// ==== hw/latch_bank.sv ====
// 24-bit input shift register and the four word latches it loads
`timescale 1ns/1ns
module latch_bank (
   input  wire logic   clk_i,
   input  wire logic   nrst_i,
   input  wire logic   clk_en_i,
   serial_evt_if.bank  evt
);

   // ----------------------------------------------------------------
   // Shift register
   // ----------------------------------------------------------------
   loader_pkg::word_t shift_reg;
   loader_pkg::latch_sel_e sel;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         shift_reg <= loader_pkg::LATCH_RESET;
      end else if (clk_en_i && evt.shift_strobe) begin
         // First bit in ends up at the top: word arrives top bit first
         shift_reg <= {shift_reg[loader_pkg::WORD_W-2:0], evt.data_bit};
      end
   end

   assign sel = loader_pkg::latch_sel_e'(shift_reg[loader_pkg::SEL_LSB +: loader_pkg::SEL_W]);

   // ----------------------------------------------------------------
   // Latches
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < loader_pkg::LATCH_N; gi++) begin : g_latch
         always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
               evt.latch[gi] <= loader_pkg::LATCH_RESET;
            end else if (clk_en_i && evt.load_strobe && (sel == loader_pkg::latch_sel_e'(gi))) begin
               // Only on a strobe edge; otherwise each latch holds
               evt.latch[gi] <= shift_reg;
            end
         end
      end
   endgenerate

endmodule : latch_bank

// ==== testbench/latch_loader_monitor.sv ====
// Port-level assertions for the three-wire latch loader
`timescale 1ns/1ns
module latch_loader_monitor (
   input wire logic                         clk_i,
   input wire logic                         nrst_i,
   input wire logic                         clk_en_i,
   input wire logic                         chip_enable_i,
   input wire logic                         load_strobe_i,
   input wire logic                         lock_detect_i,
   input wire logic                         rf_scaled_i,
   input wire logic                         ref_scaled_i,
   input wire logic                         monitor_output_o,
   input wire logic                         charge_pump_output_o,
   input wire logic                         charge_pump_output_oe_n_o,
   input wire logic                         core_power_on_o,
   input wire logic [loader_pkg::WORD_W-1:0] control_latch_o,
   input wire logic [loader_pkg::WORD_W-1:0] ref_counter_latch_o,
   input wire logic [loader_pkg::WORD_W-1:0] feedback_counter_latch_o,
   input wire logic [loader_pkg::WORD_W-1:0] test_latch_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // ----------------------------------------------------------------
   // Monitor expectation, one cycle behind its select and inputs
   // ----------------------------------------------------------------
   logic mon_exp;
   always_ff @(posedge clk_i) begin
      case (control_latch_o[loader_pkg::MON_LSB +: loader_pkg::MON_W])
         loader_pkg::MON_LOCK: mon_exp <= lock_detect_i;
         loader_pkg::MON_RF:   mon_exp <= rf_scaled_i;
         loader_pkg::MON_REF:  mon_exp <= ref_scaled_i;
         default:              mon_exp <= 1'b0;
      endcase
   end
   pump_float_a: assert property (charge_pump_output_oe_n_o |-> !charge_pump_output_o)
      else $error("pump driven high while floated");
   oe_tracks_a: assert property (charge_pump_output_oe_n_o == !core_power_on_o)
      else $error("pump enable disagrees with power");
   ce_off_a: assert property ((!chip_enable_i && clk_en_i) [*5] |-> !core_power_on_o)
      else $error("core powered with chip enable low");
   pd_gate_a: assert property (core_power_on_o |-> !$past(control_latch_o[loader_pkg::PD1_BIT])
      && !$past(control_latch_o[loader_pkg::PD2_BIT])) else $error("core powered despite power-down bit");
   mon_select_a: assert property ($past(nrst_i) && $past(clk_en_i) |-> monitor_output_o == mon_exp)
      else $error("monitor shows wrong source");
   one_load_a: assert property ($past(nrst_i) |-> $countones({!$stable(control_latch_o),
      !$stable(ref_counter_latch_o), !$stable(feedback_counter_latch_o), !$stable(test_latch_o)}) <= 1)
      else $error("several latches loaded at once");
   latch_hold_a: assert property ((!load_strobe_i) [*5] |=> $stable(control_latch_o)
      && $stable(ref_counter_latch_o) && $stable(feedback_counter_latch_o) && $stable(test_latch_o))
      else $error("latch changed without load strobe");
   route_sel_a: assert property ($past(nrst_i) |-> ($stable(ref_counter_latch_o)
      || ref_counter_latch_o[1:0] == 2'h1) && ($stable(feedback_counter_latch_o)
      || feedback_counter_latch_o[1:0] == 2'h2) && ($stable(control_latch_o) || control_latch_o[1:0] == 2'h0))
      else $error("word loaded into the wrong latch");
endmodule : latch_loader_monitor

// ==== testbench/host_model.sv ====
// Host-side model that shifts words into the serial pins
`timescale 1ns/1ns
module host_model (
   input  wire logic clk_i,
   output logic      serial_clock_o,
   output logic      serial_data_o,
   output logic      load_strobe_o
);
   initial begin
      serial_clock_o = 1'b0;
      serial_data_o = 1'b0;
      load_strobe_o = 1'b0;
   end
   task automatic send(input loader_pkg::word_t w, input logic load);
      for (int i = loader_pkg::WORD_W - 1; i >= 0; i--) begin
         @(negedge clk_i);
         serial_data_o = w[i];
         repeat (4) @(negedge clk_i);
         serial_clock_o = 1'b1;
         repeat (4) @(negedge clk_i);
         serial_clock_o = 1'b0;
      end
      // Released data line shows the inverse so a stale bit cannot pass
      serial_data_o = ~w[0];
      repeat (4) @(negedge clk_i);
      if (load && w[1:0] != 2'h3) begin
         load_strobe_o = 1'b1;
         repeat (4) @(negedge clk_i);
         load_strobe_o = 1'b0;
      end
      repeat (8) @(negedge clk_i);
   endtask : send
endmodule : host_model

// ==== testbench/three_wire_latch_loader_tb_top.sv ====
// Self-checking bench for the three-wire latch loader
`timescale 1ns/1ns
module three_wire_latch_loader_tb_top;
   logic              clk_i = 1'b0, nrst_i = 1'b0, clk_en_i = 1'b1, chip_enable_i = 1'b1;
   logic              lock_detect_i = 1'b0, rf_scaled_i = 1'b0, ref_scaled_i = 1'b0, pump_level_i = 1'b1;
   logic              serial_clock_i, serial_data_i, load_strobe_i;
   logic              monitor_output_o, charge_pump_output_o, charge_pump_output_oe_n_o, core_power_on_o;
   loader_pkg::word_t control_latch_o, ref_counter_latch_o, feedback_counter_latch_o, test_latch_o;
   int                n_mismatch = 0, n_compared = 0, cycles = 0;
   always #4 clk_i = ~clk_i;
   three_wire_latch_loader i_three_wire_latch_loader (.*);
   host_model i_host_model (.clk_i(clk_i), .serial_clock_o(serial_clock_i), .serial_data_o(serial_data_i),
      .load_strobe_o(load_strobe_i));
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   function automatic loader_pkg::word_t ctl(input logic [2:0] mon, input logic pd);
      ctl = 24'h000000;
      ctl[7:5] = mon;
      ctl[loader_pkg::PD2_BIT] = pd;
   endfunction : ctl
   // Power-up order: reference, control, then feedback
   task automatic t_load;
      i_host_model.send(24'h5A3C41, 1'b1);
      check("ref", ref_counter_latch_o, 24'h5A3C41);
      i_host_model.send(ctl(3'h1, 1'b0), 1'b1);
      check("control", control_latch_o, ctl(3'h1, 1'b0));
      i_host_model.send(24'hC3A5F2, 1'b1);
      check("feedback", feedback_counter_latch_o, 24'hC3A5F2);
      check("ref kept", ref_counter_latch_o, 24'h5A3C41);
      check("test", test_latch_o, 24'h000000);
   endtask : t_load
   task automatic t_hold;
      i_host_model.send(24'hFFFFFF, 1'b0);
      check("control held", control_latch_o, ctl(3'h1, 1'b0));
      check("feedback held", feedback_counter_latch_o, 24'hC3A5F2);
   endtask : t_hold
   // Clock enable low freezes pin capture, so a whole framed word is ignored
   task automatic t_freeze;
      clk_en_i = 1'b0;
      i_host_model.send(24'h123455, 1'b1);
      clk_en_i = 1'b1;
      repeat (4) @(negedge clk_i);
      check("frozen ref", ref_counter_latch_o, 24'h5A3C41);
   endtask : t_freeze
   task automatic t_power;
      chip_enable_i = 1'b0;
      repeat (6) @(negedge clk_i);
      check("power off", {core_power_on_o, charge_pump_output_oe_n_o, charge_pump_output_o}, 24'h2);
      chip_enable_i = 1'b1;
      repeat (6) @(negedge clk_i);
      check("power on", {core_power_on_o, charge_pump_output_oe_n_o, charge_pump_output_o}, 24'h5);
      pump_level_i = 1'b0;
      repeat (3) @(negedge clk_i);
      check("pump level", charge_pump_output_o, 24'h0);
      pump_level_i = 1'b1;
      i_host_model.send(ctl(3'h1, 1'b1), 1'b1);
      check("power down bit", {core_power_on_o, charge_pump_output_oe_n_o}, 24'h1);
   endtask : t_power
   task automatic t_mon;
      for (int m = 0; m < 5; m++) begin
         i_host_model.send(ctl(m[2:0], 1'b0), 1'b1);
         for (int s = 0; s < 3; s++) begin
            {lock_detect_i, rf_scaled_i, ref_scaled_i} = 3'b100 >> s;
            repeat (3) @(negedge clk_i);
            check("monitor", monitor_output_o, m == s + 1);
         end
      end
   endtask : t_mon
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (2) @(negedge clk_i);
      nrst_i = 1'b1;
      @(negedge clk_i);
      t_load();
      t_hold();
      t_freeze();
      t_power();
      t_mon();
      report_and_stop();
   end
endmodule : three_wire_latch_loader_tb_top
bind three_wire_latch_loader latch_loader_monitor i_latch_loader_monitor (.*);
